//--- rtl/aaj_exec_unit.sv
// Execution unit for the jump/modify and arithmetic instruction groups.
`timescale 1ns/100ps

// Function
// - Transfer op 0 loads the program counter with the effective address.
// - Transfer op 1 saves program counter plus one in accumulator 3, then jumps.
// - Transfer op 2 increments the memory word, skips on zero, keeps carry.
// - Transfer op 3 decrements the memory word, skips on zero, keeps carry.
// - Carry select gives carry, zero, one, or inverted carry.
// - Function generator makes a 16-bit result and a carry-out from two operands.
// - Rotate select 0 passes, 1 rotates left, 2 rotates right through carry.
// - Rotate select 3 swaps result bytes and keeps the carry-out.
// - Skip sensor advances the program counter once more per the 3-bit test select.
// - Skip decision is the three-bit xor/and/or form of the test select.
// - No-load bit set blocks accumulator and carry update; clear writes both.
// - Op 0 inverts the source and passes the carry.
// - Op 1 negates the source, inverting carry when the source is zero.
// - Op 2 passes source and carry unchanged.
// - Op 3 increments the source, inverting carry when it is all ones.
// - Op 4 adds target and inverted source, inverting carry on carry out.
// - Op 5 subtracts source from target, inverting carry on carry out.
// - Op 6 adds source and target, inverting carry on carry out.
// - Op 7 ands source and target and passes the carry.
module aaj_exec_unit
	import aaj_pkg::*;
(
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_issue,
	input  wire aaj_pkg::aaj_instr_type     i_instr,
	output logic                            o_busy,
	output logic                            o_done,
	output logic                            o_skipped,
	output logic [aaj_pkg::DATA_W-1:0]      o_pc,
	output logic                            o_carry,
	output logic                            o_mem_rd,
	output logic                            o_mem_wr,
	output logic [aaj_pkg::DATA_W-1:0]      o_mem_addr,
	output logic [aaj_pkg::DATA_W-1:0]      o_mem_wdata,
	input  wire logic [aaj_pkg::DATA_W-1:0] i_mem_rdata,
	input  wire logic [aaj_pkg::REG_AW-1:0] i_reg_addr,
	input  wire logic [aaj_pkg::DATA_W-1:0] i_reg_wdata,
	input  wire logic                       i_reg_wr,
	input  wire logic                       i_reg_rd,
	output logic [aaj_pkg::DATA_W-1:0]      o_reg_rdata
);
	import aaj_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] acc_ff   [NUM_ACC];
	logic [DATA_W-1:0] nxt_acc  [NUM_ACC];
	logic              carry_ff;
	logic              nxt_carry;
	logic [DATA_W-1:0] pc_ff;
	logic [DATA_W-1:0] nxt_pc;
	aaj_state_type     state_ff;
	aaj_state_type     nxt_state;
	aaj_instr_type     ins_ff;
	aaj_instr_type     nxt_ins;
	logic              mem_rd_ff;
	logic              nxt_mem_rd;
	logic              mem_wr_ff;
	logic              nxt_mem_wr;
	logic [DATA_W-1:0] addr_ff;
	logic [DATA_W-1:0] nxt_addr;
	logic [DATA_W-1:0] wdata_ff;
	logic [DATA_W-1:0] nxt_wdata;
	logic              done_ff;
	logic              nxt_done;
	logic              skipped_ff;
	logic              nxt_skipped;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;

	logic              take;
	logic [DATA_W-1:0] src_val;
	logic [DATA_W-1:0] dst_val;
	logic [DATA_W-1:0] fg_result;
	logic              fg_carry;
	logic [16:0]       sh_out;
	logic              ar_skip;
	logic              mem_zero;

	assign take     = i_issue && (state_ff == ST_IDLE);
	assign src_val  = acc_ff[i_instr.source_accumulator];
	assign dst_val  = acc_ff[i_instr.target_accumulator];
	assign mem_zero = (wdata_ff == 16'h0000);

	// ----------------------------------------------------------------
	// Arithmetic datapath
	// ----------------------------------------------------------------
	aaj_func_gen u_func_gen (
		.i_carry_in_select  (i_instr.carry_in_select),
		.i_operation_select (i_instr.operation_select),
		.i_carry            (carry_ff),
		.i_src              (src_val),
		.i_dst              (dst_val),
		.o_result           (fg_result),
		.o_carry_out        (fg_carry)
	);

	aaj_shift_skip u_shift_skip (
		.i_result             (fg_result),
		.i_carry_out          (fg_carry),
		.i_rotate_select      (i_instr.rotate_select),
		.i_branch_test_select (i_instr.branch_test_select),
		.o_shifted            (sh_out),
		.o_skip               (ar_skip)
	);

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int i = 0; i < NUM_ACC; i++)
			nxt_acc[i] = acc_ff[i];
		nxt_carry   = carry_ff;
		nxt_pc      = pc_ff;
		nxt_state   = state_ff;
		nxt_ins     = ins_ff;
		nxt_addr    = addr_ff;
		nxt_wdata   = wdata_ff;
		nxt_mem_rd  = 1'b0;
		nxt_mem_wr  = 1'b0;
		nxt_done    = 1'b0;
		nxt_skipped = 1'b0;
		nxt_rdata   = 16'h0000;

		if (i_reg_rd)
		begin
			case (i_reg_addr)
				REG_AC0, REG_AC1, REG_AC2, REG_AC3: nxt_rdata = acc_ff[i_reg_addr[1:0]];
				REG_CARRY:  nxt_rdata = {15'h0000, carry_ff};
				REG_PC:     nxt_rdata = pc_ff;
				REG_STATUS: nxt_rdata = {13'h0000, state_ff != ST_IDLE, state_ff};
				default:    nxt_rdata = 16'h0000;
			endcase
		end

		// Software writes come first so that a retiring instruction overrides them.
		if (i_reg_wr)
		begin
			case (i_reg_addr)
				REG_AC0, REG_AC1, REG_AC2, REG_AC3: nxt_acc[i_reg_addr[1:0]] = i_reg_wdata;
				REG_CARRY: nxt_carry = i_reg_wdata[0];
				REG_PC:    nxt_pc = i_reg_wdata;
				default:   nxt_pc = nxt_pc;
			endcase
		end

		case (state_ff)
			ST_IDLE:
			begin
				if (take && i_instr.is_arith)
				begin
					if (!i_instr.no_load_bit)
					begin
						nxt_acc[i_instr.target_accumulator] = sh_out[15:0];
						nxt_carry = sh_out[16];
					end
					nxt_pc      = aaj_pc_advance(pc_ff, ar_skip);
					nxt_skipped = ar_skip;
					nxt_done    = 1'b1;
				end
				else if (take)
				begin
					case (i_instr.transfer_op_select)
						TOP_JUMP:
						begin
							nxt_pc   = i_instr.eff_addr;
							nxt_done = 1'b1;
						end
						TOP_CALL:
						begin
							nxt_acc[LINK_ACC] = pc_ff + PC_STEP;
							nxt_pc   = i_instr.eff_addr;
							nxt_done = 1'b1;
						end
						default:
						begin
							nxt_ins    = i_instr;
							nxt_addr   = i_instr.eff_addr;
							nxt_mem_rd = 1'b1;
							nxt_state  = ST_RD;
						end
					endcase
				end
			end
			ST_RD:
				nxt_state = ST_WAIT;
			ST_WAIT:
			begin
				// The carry flag is left alone on this path on purpose.
				if (ins_ff.transfer_op_select == TOP_INC_SKIP)
					nxt_wdata = i_mem_rdata + PC_STEP;
				else
					nxt_wdata = i_mem_rdata - PC_STEP;
				nxt_mem_wr = 1'b1;
				nxt_state  = ST_WR;
			end
			ST_WR:
			begin
				nxt_pc      = aaj_pc_advance(pc_ff, mem_zero);
				nxt_skipped = mem_zero;
				nxt_done    = 1'b1;
				nxt_state   = ST_IDLE;
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < NUM_ACC; i++)
				acc_ff[i] <= RST_ACC;
			carry_ff   <= RST_CARRY;
			pc_ff      <= RST_PC;
			state_ff   <= ST_IDLE;
			ins_ff     <= '0;
			mem_rd_ff  <= 1'b0;
			mem_wr_ff  <= 1'b0;
			addr_ff    <= 16'h0000;
			wdata_ff   <= 16'h0000;
			done_ff    <= 1'b0;
			skipped_ff <= 1'b0;
			rdata_ff   <= 16'h0000;
		end
		else
		begin
			for (int i = 0; i < NUM_ACC; i++)
				acc_ff[i] <= nxt_acc[i];
			carry_ff   <= nxt_carry;
			pc_ff      <= nxt_pc;
			state_ff   <= nxt_state;
			ins_ff     <= nxt_ins;
			mem_rd_ff  <= nxt_mem_rd;
			mem_wr_ff  <= nxt_mem_wr;
			addr_ff    <= nxt_addr;
			wdata_ff   <= nxt_wdata;
			done_ff    <= nxt_done;
			skipped_ff <= nxt_skipped;
			rdata_ff   <= nxt_rdata;
		end
	end

	assign o_busy      = (state_ff != ST_IDLE);
	assign o_done      = done_ff;
	assign o_skipped   = skipped_ff;
	assign o_pc        = pc_ff;
	assign o_carry     = carry_ff;
	assign o_mem_rd    = mem_rd_ff;
	assign o_mem_wr    = mem_wr_ff;
	assign o_mem_addr  = addr_ff;
	assign o_mem_wdata = wdata_ff;
	assign o_reg_rdata = rdata_ff;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	logic take_jump;
	logic take_call;
	logic take_inc;
	logic take_dec;
	logic take_arith;

	assign take_jump  = take && !i_instr.is_arith && i_instr.transfer_op_select == TOP_JUMP;
	assign take_call  = take && !i_instr.is_arith && i_instr.transfer_op_select == TOP_CALL;
	assign take_inc   = take && !i_instr.is_arith && i_instr.transfer_op_select == TOP_INC_SKIP;
	assign take_dec   = take && !i_instr.is_arith && i_instr.transfer_op_select == TOP_DEC_SKIP;
	assign take_arith = take && i_instr.is_arith;

	sequence s_mem_read;
		o_mem_rd && !o_mem_wr ##1 !o_mem_rd;
	endsequence

	property p_jump;
		take_jump && !i_reg_wr |=> o_done && pc_ff == $past(i_instr.eff_addr);
	endproperty
	a_jump: assert property (p_jump) else $error("jump did not load pc");

	property p_call;
		take_call && !i_reg_wr |=> acc_ff[3] == $past(pc_ff) + PC_STEP
			&& pc_ff == $past(i_instr.eff_addr);
	endproperty
	a_call: assert property (p_call) else $error("call link or target wrong");

	property p_inc_mem;
		take_inc |=> s_mem_read ##1 (o_mem_wr
			&& o_mem_wdata == $past(i_mem_rdata) + PC_STEP) ##1 o_done;
	endproperty
	a_inc_mem: assert property (p_inc_mem) else $error("increment cycle wrong");

	property p_dec_mem;
		take_dec |=> s_mem_read ##1 (o_mem_wr
			&& o_mem_wdata == $past(i_mem_rdata) - PC_STEP) ##1 o_done;
	endproperty
	a_dec_mem: assert property (p_dec_mem) else $error("decrement cycle wrong");

	property p_mem_keep_carry;
		(take_inc || take_dec) && !i_reg_wr ##1 (!i_reg_wr) [*3] |->
			carry_ff == $past(carry_ff, 3);
	endproperty
	a_mem_keep_carry: assert property (p_mem_keep_carry) else $error("carry moved");

	property p_mem_skip;
		state_ff == ST_WR && !i_reg_wr |=> o_skipped == (wdata_ff == 16'h0000) && o_done
			&& pc_ff == $past(pc_ff) + (o_skipped ? PC_SKIP : PC_STEP);
	endproperty
	a_mem_skip: assert property (p_mem_skip) else $error("memory skip wrong");

	property p_no_load;
		take_arith && i_instr.no_load_bit && !i_reg_wr |=> $stable(carry_ff)
			&& acc_ff[0] == $past(acc_ff[0]) && acc_ff[3] == $past(acc_ff[3]);
	endproperty
	a_no_load: assert property (p_no_load) else $error("no-load still wrote");

	property p_load;
		take_arith && !i_instr.no_load_bit && !i_reg_wr |=> carry_ff == $past(sh_out[16]);
	endproperty
	a_load: assert property (p_load) else $error("carry writeback wrong");

	property p_arith_pc;
		take_arith && !i_reg_wr |=> o_done
			&& pc_ff == $past(pc_ff) + (o_skipped ? PC_SKIP : PC_STEP);
	endproperty
	a_arith_pc: assert property (p_arith_pc) else $error("arith pc advance wrong");

	property p_swap;
		i_instr.rotate_select == ROT_SWAP |-> sh_out[16] == fg_carry
			&& sh_out[7:0] == fg_result[15:8] && sh_out[15:8] == fg_result[7:0];
	endproperty
	a_swap: assert property (p_swap) else $error("byte swap wrong");

	property p_carry_const;
		i_instr.operation_select == OP_PASS && i_instr.carry_in_select == CY_ONE |-> fg_carry;
	endproperty
	a_carry_const: assert property (p_carry_const) else $error("carry one lost");
endmodule

//--- inc/aaj_pkg.sv
// Shared constants, types and helper functions of the accumulator ALU and jump unit.
package aaj_pkg;

	// ----------------------------------------------------------------
	// Widths and register map
	// ----------------------------------------------------------------
	localparam int          DATA_W      = 16;
	localparam int          NUM_ACC     = 4;
	localparam int          REG_AW      = 3;
	localparam logic [2:0]  REG_AC0     = 3'h0;
	localparam logic [2:0]  REG_AC1     = 3'h1;
	localparam logic [2:0]  REG_AC2     = 3'h2;
	localparam logic [2:0]  REG_AC3     = 3'h3;
	localparam logic [2:0]  REG_CARRY   = 3'h4;
	localparam logic [2:0]  REG_PC      = 3'h5;
	localparam logic [2:0]  REG_STATUS  = 3'h6;
	localparam logic [1:0]  LINK_ACC    = 2'h3;
	localparam logic [15:0] RST_PC      = 16'h0000;
	localparam logic [15:0] RST_ACC     = 16'h0000;
	localparam logic        RST_CARRY   = 1'b0;
	localparam logic [15:0] PC_STEP     = 16'h0001;
	localparam logic [15:0] PC_SKIP     = 16'h0002;
	localparam logic [15:0] ALL_ONES    = 16'hFFFF;

	// ----------------------------------------------------------------
	// Field encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] TOP_JUMP     = 2'h0;
	localparam logic [1:0] TOP_CALL     = 2'h1;
	localparam logic [1:0] TOP_INC_SKIP = 2'h2;
	localparam logic [1:0] TOP_DEC_SKIP = 2'h3;
	localparam logic [1:0] CY_KEEP      = 2'h0;
	localparam logic [1:0] CY_ZERO      = 2'h1;
	localparam logic [1:0] CY_ONE       = 2'h2;
	localparam logic [1:0] CY_INVERT    = 2'h3;
	localparam logic [2:0] OP_INVERT    = 3'h0;
	localparam logic [2:0] OP_MINUS     = 3'h1;
	localparam logic [2:0] OP_PASS      = 3'h2;
	localparam logic [2:0] OP_INC       = 3'h3;
	localparam logic [2:0] OP_ADD_INV   = 3'h4;
	localparam logic [2:0] OP_SUB       = 3'h5;
	localparam logic [2:0] OP_ADD       = 3'h6;
	localparam logic [2:0] OP_AND       = 3'h7;
	localparam logic [1:0] ROT_NONE     = 2'h0;
	localparam logic [1:0] ROT_LEFT     = 2'h1;
	localparam logic [1:0] ROT_RIGHT    = 2'h2;
	localparam logic [1:0] ROT_SWAP     = 2'h3;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        is_arith;
		logic [1:0]  transfer_op_select;
		logic [15:0] eff_addr;
		logic [1:0]  source_accumulator;
		logic [1:0]  target_accumulator;
		logic [2:0]  operation_select;
		logic [1:0]  carry_in_select;
		logic [1:0]  rotate_select;
		logic        no_load_bit;
		logic [2:0]  branch_test_select;
	} aaj_instr_type;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_RD   = 2'h1,
		ST_WAIT = 2'h3,
		ST_WR   = 2'h2
	} aaj_state_type;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic aaj_skip_test(input logic [2:0] sel, input logic cy,
		input logic [15:0] res);
		aaj_skip_test = sel[0] ^ ((sel[2] & (res == 16'h0000)) | (sel[1] & ~cy));
	endfunction

	function automatic logic [15:0] aaj_pc_advance(input logic [15:0] pc, input logic skip);
		aaj_pc_advance = skip ? pc + PC_SKIP : pc + PC_STEP;
	endfunction

endpackage

//--- rtl/aaj_func_gen.sv
// Carry generator and eight-way function generator.
`timescale 1ns/100ps
module aaj_func_gen
	import aaj_pkg::*;
(
	input  wire logic [1:0]  i_carry_in_select,
	input  wire logic [2:0]  i_operation_select,
	input  wire logic        i_carry,
	input  wire logic [15:0] i_src,
	input  wire logic [15:0] i_dst,
	output logic [15:0]      o_result,
	output logic             o_carry_out
);
	logic        cin;
	logic [16:0] sum;

	always_comb
	begin
		case (i_carry_in_select)
			CY_KEEP:  cin = i_carry;
			CY_ZERO:  cin = 1'b0;
			CY_ONE:   cin = 1'b1;
			default:  cin = ~i_carry;
		endcase
		sum         = 17'h00000;
		o_result    = i_src;
		o_carry_out = cin;
		case (i_operation_select)
			OP_INVERT: o_result = ~i_src;
			OP_MINUS:
			begin
				o_result    = 16'h0000 - i_src;
				o_carry_out = cin ^ (i_src == 16'h0000);
			end
			OP_PASS:   o_result = i_src;
			OP_INC:
			begin
				o_result    = i_src + PC_STEP;
				o_carry_out = cin ^ (i_src == ALL_ONES);
			end
			OP_ADD_INV, OP_SUB, OP_ADD:
			begin
				// Subtraction is the inverted add with a forced one, so all three share one adder.
				if (i_operation_select == OP_ADD)
					sum = {1'b0, i_dst} + {1'b0, i_src};
				else if (i_operation_select == OP_SUB)
					sum = {1'b0, i_dst} + {1'b0, ~i_src} + 17'h00001;
				else
					sum = {1'b0, i_dst} + {1'b0, ~i_src};
				o_result    = sum[15:0];
				o_carry_out = cin ^ sum[16];
			end
			default:   o_result = i_src & i_dst;
		endcase
	end
endmodule

//--- rtl/aaj_shift_skip.sv
// Seventeen-bit shifter and skip sensor.
`timescale 1ns/100ps
module aaj_shift_skip
	import aaj_pkg::*;
(
	input  wire logic [15:0] i_result,
	input  wire logic        i_carry_out,
	input  wire logic [1:0]  i_rotate_select,
	input  wire logic [2:0]  i_branch_test_select,
	output logic [16:0]      o_shifted,
	output logic             o_skip
);
	always_comb
	begin
		case (i_rotate_select)
			ROT_NONE:  o_shifted = {i_carry_out, i_result};
			ROT_LEFT:  o_shifted = {i_result[15], i_result[14:0], i_carry_out};
			ROT_RIGHT: o_shifted = {i_result[0], i_carry_out, i_result[15:1]};
			default:   o_shifted = {i_carry_out, i_result[7:0], i_result[15:8]};
		endcase
		// The sensor looks at the shifted word, never at the raw function output.
		o_skip = aaj_skip_test(i_branch_test_select, o_shifted[16], o_shifted[15:0]);
	end
endmodule

//--- testbench/aaj_mem_model.sv
// Main memory partner model for the accumulator ALU and jump unit.
`timescale 1ns/100ps
module aaj_mem_model
(
	input  wire logic        i_clk,
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [15:0] i_addr,
	input  wire logic [15:0] i_wdata,
	output logic [15:0]      o_rdata
);
	logic [15:0] store [logic [15:0]];

	initial
	begin
		o_rdata = 16'h0000;
	end

	// Read data stand only in the cycle after the read; otherwise the bus toggles,
	// so a late sample shows up as wrong data instead of a lucky match.
	always @(posedge i_clk)
	begin
		if (i_rd)
			o_rdata <= store.exists(i_addr) ? store[i_addr] : ~i_addr;
		else
			o_rdata <= ~o_rdata;
		if (i_wr)
			store[i_addr] = i_wdata;
	end
endmodule

//--- testbench/test_accumulator_alu_jump_unit.sv
// Self-checking testbench of the accumulator ALU and jump unit.
`timescale 1ns/100ps
module test_accumulator_alu_jump_unit;
	import aaj_pkg::*;
	logic          i_clk;
	logic          i_rst_n;
	logic          i_issue;
	aaj_instr_type i_instr;
	logic [2:0]    i_reg_addr;
	logic [15:0]   i_reg_wdata;
	logic          i_reg_wr;
	logic          i_reg_rd;
	logic [15:0]   i_mem_rdata;
	logic          o_busy;
	logic          o_done;
	logic          o_skipped;
	logic          o_carry;
	logic          o_mem_rd;
	logic          o_mem_wr;
	logic [15:0]   o_pc;
	logic [15:0]   o_mem_addr;
	logic [15:0]   o_mem_wdata;
	logic [15:0]   o_reg_rdata;
	int            miscompares;
	int            samples_checked;
	int            cycles = 0;
	logic [31:0]   seed;
	logic [15:0]   m_acc [4];
	logic [15:0]   m_pc;
	logic          m_cy;
	logic [15:0]   m_mem [logic [15:0]];
	aaj_instr_type ins;
	logic [15:0]   v;

	aaj_exec_unit dut (.i_clk, .i_rst_n, .i_issue, .i_instr, .o_busy, .o_done, .o_skipped,
		.o_pc, .o_carry, .o_mem_rd, .o_mem_wr, .o_mem_addr, .o_mem_wdata, .i_mem_rdata,
		.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata);
	aaj_mem_model mem (.i_clk, .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// Generous ceiling: the whole run needs well under a quarter of it.
	always @(posedge i_clk)
	begin
		cycles++;
		if (cycles > 40000)
		begin
			miscompares++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		xs = t ^ (t << 5);
	endfunction

	function automatic logic [15:0] pick(input logic [1:0] k, input logic [15:0] r);
		pick = (k == 2'h0) ? 16'h0000 : ((k == 2'h1) ? 16'hFFFF : r);
	endfunction

	task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic chk1(input string n, input logic e, input logic g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %b seen %b", n, e, g);
		end
	endtask

	task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_reg_wr <= 1'b1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_clk);
		i_reg_wr <= 1'b0;
	endtask

	task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge i_clk);
		i_reg_rd <= 1'b1;
		i_reg_addr <= a;
		@(posedge i_clk);
		i_reg_rd <= 1'b0;
		#1;
		d = o_reg_rdata;
	endtask

	// A poke re-issues a jump while the unit is busy; it must be ignored.
	task automatic issue(input aaj_instr_type x, input logic poke);
		int n;
		int lat;
		lat = (!x.is_arith && x.transfer_op_select[1]) ? (poke ? 2 : 3) : 0;
		@(posedge i_clk);
		i_issue <= 1'b1;
		i_instr <= x;
		@(posedge i_clk);
		i_issue <= poke;
		i_instr <= '0;
		if (poke)
		begin
			@(posedge i_clk);
			i_issue <= 1'b0;
		end
		n = 0;
		#1;
		chk1("busy", lat != 0, o_busy);
		while (o_done !== 1'b1 && n < 8)
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		chk16("latency", lat[15:0], n[15:0]);
		chk1("busy after retire", 1'b0, o_busy);
	endtask

	task automatic model_arith(input aaj_instr_type x, output logic sk);
		logic [15:0] s;
		logic [15:0] d;
		logic [15:0] r;
		logic [16:0] sh;
		logic        ci;
		logic        co;
		logic        z;
		s = m_acc[x.source_accumulator];
		d = m_acc[x.target_accumulator];
		ci = (x.carry_in_select == 2'h0) ? m_cy : ((x.carry_in_select == 2'h3) ? ~m_cy :
			x.carry_in_select[1]);
		case (x.operation_select)
			3'h0: {co, r} = {ci, ~s};
			3'h1: {co, r} = {ci ^ (s == 16'h0000), -s};
			3'h2: {co, r} = {ci, s};
			3'h3: {co, r} = {ci ^ (s == 16'hFFFF), s + 16'h0001};
			3'h4: {co, r} = {ci, 16'h0000} ^ ({1'b0, d} + {1'b0, ~s});
			3'h5: {co, r} = {ci, 16'h0000} ^ ({1'b0, d} + {1'b0, ~s} + 17'h00001);
			3'h6: {co, r} = {ci, 16'h0000} ^ ({1'b0, d} + {1'b0, s});
			default: {co, r} = {ci, s & d};
		endcase
		case (x.rotate_select)
			2'h0: sh = {co, r};
			2'h1: sh = {r, co};
			2'h2: sh = {r[0], co, r[15:1]};
			default: sh = {co, r[7:0], r[15:8]};
		endcase
		z = (sh[15:0] == 16'h0000);
		case (x.branch_test_select)
			3'h0: sk = 1'b0;
			3'h1: sk = 1'b1;
			3'h2: sk = ~sh[16];
			3'h3: sk = sh[16];
			3'h4: sk = z;
			3'h5: sk = ~z;
			3'h6: sk = z | ~sh[16];
			default: sk = ~z & sh[16];
		endcase
		if (!x.no_load_bit)
		begin
			m_acc[x.target_accumulator] = sh[15:0];
			m_cy = sh[16];
		end
		m_pc = m_pc + (sk ? 16'h0002 : 16'h0001);
	endtask

	// Issue one instruction, advance the model and compare every visible result.
	task automatic run(input aaj_instr_type x, input logic poke);
		logic        sk;
		logic [15:0] nv;
		logic [15:0] e;
		logic [15:0] d;
		sk = 1'b0;
		e = x.eff_addr;
		issue(x, poke);
		if (x.is_arith)
			model_arith(x, sk);
		else if (x.transfer_op_select[1])
		begin
			nv = x.transfer_op_select[0] ? m_mem[e] - 16'h0001 : m_mem[e] + 16'h0001;
			m_mem[e] = nv;
			sk = (nv == 16'h0000);
			m_pc = m_pc + (sk ? 16'h0002 : 16'h0001);
			chk16("memory", nv, mem.store[e]);
		end
		else
		begin
			if (x.transfer_op_select[0])
				m_acc[3] = m_pc + 16'h0001;
			m_pc = e;
		end
		chk1("skipped", sk, o_skipped);
		chk16("pc", m_pc, o_pc);
		chk1("carry", m_cy, o_carry);
		for (int a = 0; a < 4; a++)
		begin
			reg_rd(a[2:0], d);
			chk16("accumulator", m_acc[a], d);
		end
	endtask

	task automatic finish_test();
		$display("Checks made %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		i_rst_n = 1'b0;
		i_issue = 1'b0;
		i_instr = '0;
		i_reg_addr = 3'h0;
		i_reg_wdata = 16'h0000;
		i_reg_wr = 1'b0;
		i_reg_rd = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		seed = 32'h1FFC;
		m_acc = '{default: 16'h0000};
		m_pc = 16'h0000;
		m_cy = 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		reg_wr(3'h7, 16'hFFFF);
		reg_rd(3'h7, v);
		chk16("unmapped", 16'h0000, v);
		reg_rd(3'h6, v);
		chk16("status", 16'h0000, v);
		$display("Reset and register port test done");
		for (int i = 0; i < 256; i++)
		begin
			seed = xs(seed);
			ins = '0;
			ins.is_arith = 1'b1;
			ins.operation_select = i[2:0];
			ins.branch_test_select = i[5:3];
			ins.rotate_select = i[7:6];
			ins.carry_in_select = seed[1:0];
			ins.no_load_bit = seed[2] & seed[3];
			ins.source_accumulator = seed[5:4];
			ins.target_accumulator = seed[7:6];
			ins.eff_addr = seed[31:16];
			v = pick(seed[9:8], seed[31:16]);
			reg_wr({1'b0, seed[5:4]}, v);
			m_acc[seed[5:4]] = v;
			v = pick(seed[11:10], seed[27:12]);
			reg_wr({1'b0, seed[7:6]}, v);
			m_acc[seed[7:6]] = v;
			reg_wr(3'h4, {15'h0000, seed[12]});
			m_cy = seed[12];
			run(ins, 1'b0);
		end
		$display("Arithmetic group test done");
		ins = '0;
		ins.eff_addr = 16'h1234;
		run(ins, 1'b0);
		ins.transfer_op_select = 2'h1;
		ins.eff_addr = 16'h4321;
		run(ins, 1'b0);
		$display("Jump and call test done");
		reg_wr(3'h4, 16'h0001);
		m_cy = 1'b1;
		reg_wr(3'h5, 16'hFFFE);
		m_pc = 16'hFFFE;
		for (int k = 0; k < 5; k++)
		begin
			ins = '0;
			ins.transfer_op_select = k[0] ? 2'h3 : 2'h2;
			ins.eff_addr = 16'h0100 + 16'(k);
			v = (k == 4) ? 16'h0000 : (k[1] ? 16'h7FFF : (k[0] ? 16'h0001 : 16'hFFFF));
			mem.store[ins.eff_addr] = v;
			m_mem[ins.eff_addr] = v;
			run(ins, k[1]);
		end
		reg_rd(3'h5, v);
		chk16("pc register", m_pc, v);
		reg_rd(3'h4, v);
		chk16("carry register", {15'h0000, m_cy}, v);
		$display("Memory modify test done");
		finish_test();
	end
endmodule
